// *** src/bfs_map.svh ***
// Constants of the bus frame field sequencer
`ifndef BFS_MAP_SVH
`define BFS_MAP_SVH
`define BFS_BIT_CYC   8
`define BFS_MAX_M0    16
`define BFS_MAX_M1    32
`define BFS_ADR_ALL   12'hFFF
`define BFS_GRP_HI    11
`define BFS_GRP_LO    8
`define BFS_DIR_BIT   3
`define BFS_ACK       1'b0
`define BFS_BC_FLAG   1'b0
`define BFS_ADR_LAST  4'hB
`define BFS_CTL_LAST  4'h3
`define BFS_BYTE_LAST 4'h7
`endif

// *** src/bfs_pkg.sv ***
// Types and helpers shared by both ends of the frame sequencer
package bfs_pkg;
  typedef enum logic [7:0] {
    FLD_IDLE = 8'h01,
    FLD_BC   = 8'h02,
    FLD_MADR = 8'h04,
    FLD_SADR = 8'h08,
    FLD_CTRL = 8'h10,
    FLD_LEN  = 8'h20,
    FLD_DATA = 8'h40,
    FLD_REST = 8'h80
  } bfs_fld_e;
  typedef enum logic [2:0] {
    PH_BITS = 3'h1,
    PH_PAR  = 3'h2,
    PH_ACK  = 3'h4
  } bfs_ph_e;
  typedef enum logic [2:0] {
    RES_OK    = 3'h0,
    RES_NADR  = 3'h1,
    RES_NCTL  = 3'h2,
    RES_NLEN  = 3'h3,
    RES_BREAD = 3'h4
  } bfs_res_e;
  // Length code 00 stands for 256 bytes
  function automatic logic [8:0] bfs_len_bytes(input logic [7:0] c);
    return {(c == 8'h00), c};
  endfunction : bfs_len_bytes
  function automatic logic [7:0] bfs_len_code(input logic [8:0] nb);
    return nb[7:0];
  endfunction : bfs_len_code
endpackage : bfs_pkg

// *** src/bfs_if.sv ***
// Shared wired-AND frame line between master and slave ends
interface bfs_if;
  logic frame;
  logic stb;
  logic m_o;
  logic m_oe;
  logic s_o;
  logic s_oe;
  logic bus;
  // A released end counts as high; any low wins
  assign bus = (~m_oe | m_o) & (~s_oe | s_o);
  modport mst (output frame, output stb, output m_o, output m_oe, input bus);
  modport slv (input frame, input stb, output s_o, output s_oe, input bus);
endinterface : bfs_if

// *** src/bfs_slave.sv ***
// Slave end of the frame field sequencer
`include "bfs_map.svh"
module bfs_slave #(
  parameter int MAX_M0 = `BFS_MAX_M0, // byte slots per frame, mode 0
  parameter int MAX_M1 = `BFS_MAX_M1  // byte slots per frame, mode 1
) (
  input  wire logic        clock,    // system clock
  input  wire logic        resetn,   // synchronous reset, active low
  input  wire logic        ce,       // clock enable
  input  wire logic        mode,     // communication mode
  input  wire logic [11:0] own_adr,  // own unit address
  input  wire logic        func_ok,  // control code can be served
  input  wire logic        rx_full,  // receive buffer not empty
  input  wire logic [7:0]  tx_len,   // read length code
  input  wire logic [7:0]  tx_data,  // next byte to send
  output logic             tx_take,  // tx_data taken
  output logic [7:0]       rx_data,  // accepted byte
  output logic             rx_vld,   // rx_data valid
  output logic             sel,      // unit addressed in this frame
  output logic             bc_rx,    // broadcast bit of frame
  output logic [3:0]       ctl_rx,   // received control code
  output logic [11:0]      mad_rx,   // received master address
  bfs_if.slv               lnk       // frame line
);
  if (MAX_M0 < 1 || MAX_M0 > 256 || MAX_M1 < 1 || MAX_M1 > 256) begin : g_bad
    $error("bfs_slave: byte maximum out of range");
  end

  typedef struct packed {
    bfs_pkg::bfs_fld_e st;
    bfs_pkg::bfs_ph_e  ph;
    logic [3:0]        idx;
    logic [11:0]       sh;
    logic              par;
    logic              ok;
    logic              mok;
    logic              bc;
    logic              rd;
    logic              sel;
    logic [11:0]       mad;
    logic [3:0]        ctl;
    logic [8:0]        rem;
    logic [8:0]        nfr;
    logic [7:0]        tb;
    logic              pend;
    logic              o;
    logic              oe;
    logic              tx_take;
    logic              rx_vld;
    logic [7:0]        rx_data;
  } bfs_s_s;

  localparam bfs_s_s RST = '{st: bfs_pkg::FLD_IDLE, ph: bfs_pkg::PH_BITS, bc: 1'b1, o: 1'b1, default: '0};

  bfs_s_s     q;
  bfs_s_s     n;
  logic       b;
  logic       bcm;
  logic       ack;
  logic       acc;
  logic       mine;
  logic [8:0] rm;
  logic [8:0] nf;
  logic [8:0] maxb;

  function automatic bfs_s_s fld(input bfs_s_s s, input bfs_pkg::bfs_fld_e f, input logic [3:0] i,
                                 input logic [11:0] v);
    s.st = f;
    s.ph = bfs_pkg::PH_BITS;
    s.idx = i;
    s.sh = v;
    s.par = 1'b0;
    return s;
  endfunction : fld

  // A byte that was refused stays pending and is resent
  function automatic bfs_s_s ld_data(input bfs_s_s s, input logic [7:0] tx);
    s = fld(s, bfs_pkg::FLD_DATA, `BFS_BYTE_LAST, 12'h000);
    if (s.rd && s.pend) begin
      s.sh = {s.tb, 4'h0};
    end else if (s.rd) begin
      s.sh = {tx, 4'h0};
      s.tb = tx;
      s.pend = 1'b1;
      s.tx_take = 1'b1;
    end
    return s;
  endfunction : ld_data

  always_comb begin
    n = q;
    n.tx_take = 1'b0;
    n.rx_vld = 1'b0;
    b = lnk.bus;
    bcm = (q.bc == `BFS_BC_FLAG);
    ack = (b == `BFS_ACK);
    acc = 1'b0;
    rm = q.rem;
    nf = q.nfr + 9'h001;
    maxb = mode ? 9'(MAX_M1) : 9'(MAX_M0);
    if (!lnk.frame) begin
      if (q.st != bfs_pkg::FLD_IDLE) begin
        n.st = bfs_pkg::FLD_IDLE;
        n.sel = 1'b0;
        n.rd = 1'b0;
      end
    end else if (lnk.stb) begin
      if (q.ph == bfs_pkg::PH_BITS) begin // see R1
        n.sh = {q.sh[10:0], b};
        n.par = q.par ^ b;
        if (q.idx != 4'h0) n.idx = q.idx - 4'h1;
        else n.ph = bfs_pkg::PH_PAR;
      end else if (q.ph == bfs_pkg::PH_PAR) begin
        n.ok = (q.par == b); // see R20
        n.ph = bfs_pkg::PH_ACK;
      end
      case (q.st)
        bfs_pkg::FLD_IDLE: begin
          n.bc = b; // see R22
          n.nfr = 9'h000;
          n.ok = 1'b0;
          n = fld(n, bfs_pkg::FLD_MADR, `BFS_ADR_LAST, 12'h000);
        end
        bfs_pkg::FLD_MADR: begin
          if (q.ph == bfs_pkg::PH_PAR) begin
            n.mad = q.sh;
            n.mok = (q.par == b);
            n = fld(n, bfs_pkg::FLD_SADR, `BFS_ADR_LAST, 12'h000);
          end
        end
        bfs_pkg::FLD_SADR: begin
          if (q.ph == bfs_pkg::PH_PAR) begin
            if (bcm) begin // see R4 R5
              n.ok = (q.par == b) && q.mok &&
                     (q.sh == `BFS_ADR_ALL || q.sh[`BFS_GRP_HI:`BFS_GRP_LO] == own_adr[`BFS_GRP_HI:`BFS_GRP_LO]);
            end else begin
              n.ok = (q.par == b) && q.mok && (q.sh == own_adr); // see R3
            end
          end else if (q.ph == bfs_pkg::PH_ACK) begin
            if (q.ok) begin
              n.sel = 1'b1;
              n = fld(n, bfs_pkg::FLD_CTRL, `BFS_CTL_LAST, 12'h000);
            end else begin
              n.st = bfs_pkg::FLD_REST;
            end
          end
        end
        bfs_pkg::FLD_CTRL: begin
          if (q.ph == bfs_pkg::PH_BITS && q.idx == 4'h0) begin
            n.ctl = {q.sh[2:0], b}; // see R6
          end else if (q.ph == bfs_pkg::PH_PAR) begin
            // A broadcast never carries a read
            n.ok = (q.par == b) && (bcm ? q.ctl[`BFS_DIR_BIT] : func_ok); // see R7 R15
          end else if (q.ph == bfs_pkg::PH_ACK) begin
            if (q.ok) begin
              n.rd = ~q.ctl[`BFS_DIR_BIT]; // see R11
              n = fld(n, bfs_pkg::FLD_LEN, `BFS_BYTE_LAST, 12'h000);
              if (n.rd) begin
                n.sh = {tx_len, 4'h0}; // see R9 R13
                n.rem = bfs_pkg::bfs_len_bytes(tx_len);
              end
            end else begin
              n.st = bfs_pkg::FLD_REST;
            end
          end
        end
        bfs_pkg::FLD_LEN: begin
          if (q.ph == bfs_pkg::PH_PAR) begin
            if (q.rd) n.ok = 1'b0;
            else n.rem = bfs_pkg::bfs_len_bytes(q.sh[7:0]); // see R12
          end else if (q.ph == bfs_pkg::PH_ACK) begin
            if (q.rd ? ack : q.ok) n = ld_data(n, tx_data);
            else n.st = bfs_pkg::FLD_REST;
          end
        end
        bfs_pkg::FLD_DATA: begin
          if (q.ph == bfs_pkg::PH_PAR) begin
            n.ok = !q.rd && (q.par == b) && !rx_full; // see R16
          end else if (q.ph == bfs_pkg::PH_ACK) begin
            acc = q.rd ? ack : q.ok; // see R19
            if (acc) begin
              rm = q.rem - 9'h001;
              n.pend = 1'b0;
              n.rx_vld = !q.rd;
              n.rx_data = q.sh[7:0];
            end
            n.rem = rm;
            n.nfr = nf;
            if (rm == 9'h000 || nf == maxb) n.st = bfs_pkg::FLD_REST; // see R24
            else n = ld_data(n, tx_data);
          end
        end
        default: begin
        end
      endcase
    end
    // Drive for the position just reached
    mine = n.rd && (n.st == bfs_pkg::FLD_LEN || n.st == bfs_pkg::FLD_DATA);
    n.oe = 1'b0;
    n.o = 1'b1;
    if (n.st == bfs_pkg::FLD_SADR || n.st == bfs_pkg::FLD_CTRL || n.st == bfs_pkg::FLD_LEN ||
        n.st == bfs_pkg::FLD_DATA) begin
      if (n.ph == bfs_pkg::PH_BITS && mine) begin
        n.oe = 1'b1;
        n.o = n.sh[11];
      end else if (n.ph == bfs_pkg::PH_PAR && mine) begin
        n.oe = 1'b1;
        n.o = n.par; // see R20
      end else if (n.ph == bfs_pkg::PH_ACK && !mine && n.ok && n.bc != `BFS_BC_FLAG) begin
        n.oe = 1'b1;
        n.o = `BFS_ACK; // see R21 R23
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign tx_take  = q.tx_take;
  assign rx_data  = q.rx_data;
  assign rx_vld   = q.rx_vld;
  assign sel      = q.sel;
  assign bc_rx    = q.bc;
  assign ctl_rx   = q.ctl;
  assign mad_rx   = q.mad;
  assign lnk.s_o  = q.o;
  assign lnk.s_oe = q.oe;
endmodule : bfs_slave

// *** src/bfs_master.sv ***
// Master end of the frame field sequencer
`include "bfs_map.svh"
// Overview of operation
// R1: Slave address: 12 bits MSB first, parity, ack
// R2: Master waits for address ack unless broadcast
// R3: Slave acks only own address, even parities
// R4: All-ones target means general broadcast
// R5: Group broadcast matches upper four address bits
// R6: Control: four bits MSB first, parity, ack
// R7: Slave acks control if even and servable
// R8: No control ack ends frame; broadcast continues
// R9: Length eight bits; code 00 means 256
// R10: Long transfers split; later frames carry remainder
// R11: Control bit 3 sets length/data direction
// R12: Write length: slave acks even parity only
// R13: Read length: slave sends, master acks even
// R14: Data byte: eight bits, parity, ack
// R15: Broadcast only writes; acks ignored, once each
// R16: Slave acks byte if even and buffer empty
// R17: Write byte resent on NAK within maximum
// R18: Master times every bit; slave follows it
// R19: Read byte refused on odd or full; reread
// R20: Even parity per field, bit one if odd
// R21: Ack low means accepted; broadcast ignores it
// R22: Broadcast flag zero means broadcast frame
// R23: Line is wired-AND; any low wins
// R24: Byte maximum per frame set by mode
module bfs_master #(
  parameter int BIT_CYC = `BFS_BIT_CYC, // clock cycles per bus bit
  parameter int MAX_M0  = `BFS_MAX_M0,  // byte slots per frame, mode 0
  parameter int MAX_M1  = `BFS_MAX_M1   // byte slots per frame, mode 1
) (
  input  wire logic         clock,   // system clock
  input  wire logic         resetn,  // synchronous reset, active low
  input  wire logic         ce,      // clock enable
  input  wire logic         mode,    // communication mode
  input  wire logic         start,   // begin a transfer when idle
  input  wire logic         bcast,   // broadcast flag to send
  input  wire logic [11:0]  own_adr, // own master address
  input  wire logic [11:0]  dst_adr, // target address
  input  wire logic [3:0]   ctl,     // control code
  input  wire logic [7:0]   len,     // write length code
  input  wire logic [7:0]   tx_data, // next byte to send
  input  wire logic         rx_full, // receive buffer not empty
  output logic              tx_take, // tx_data taken
  output logic [7:0]        rx_data, // accepted byte
  output logic              rx_vld,  // rx_data valid
  output logic              busy,    // transfer in progress
  output logic              done,    // transfer finished
  output bfs_pkg::bfs_res_e res,     // outcome of last transfer
  bfs_if.mst                lnk      // frame line
);
  if (BIT_CYC < 4 || BIT_CYC > 255 || MAX_M0 < 1 || MAX_M0 > 256 || MAX_M1 < 1 || MAX_M1 > 256)
  begin : g_bad
    $error("bfs_master: parameter out of range");
  end

  localparam logic [7:0] LAST = 8'(BIT_CYC - 1);
  localparam logic [7:0] PRE  = 8'(BIT_CYC - 2);

  typedef struct packed {
    bfs_pkg::bfs_fld_e st;
    bfs_pkg::bfs_ph_e  ph;
    logic [3:0]        idx;
    logic [7:0]        cnt;
    logic [11:0]       sh;
    logic              par;
    logic              ok;
    logic              bc;
    logic              rd;
    logic [11:0]       mad;
    logic [11:0]       sad;
    logic [3:0]        ctl;
    logic [8:0]        rem;
    logic [8:0]        nfr;
    logic [7:0]        tb;
    logic              pend;
    logic              o;
    logic              oe;
    logic              stb;
    logic              frame;
    logic              tx_take;
    logic              rx_vld;
    logic [7:0]        rx_data;
    logic              busy;
    logic              done;
    bfs_pkg::bfs_res_e res;
  } bfs_m_s;

  localparam bfs_m_s RST = '{st: bfs_pkg::FLD_IDLE, ph: bfs_pkg::PH_BITS, res: bfs_pkg::RES_OK, o: 1'b1,
                             default: '0};

  bfs_m_s     q;
  bfs_m_s     n;
  logic       b;
  logic       bcm;
  logic       ack;
  logic       acc;
  logic       mine;
  logic [8:0] rm;
  logic [8:0] nf;
  logic [8:0] maxb;

  function automatic bfs_m_s fld(input bfs_m_s s, input bfs_pkg::bfs_fld_e f, input logic [3:0] i,
                                 input logic [11:0] v);
    s.st = f;
    s.ph = bfs_pkg::PH_BITS;
    s.idx = i;
    s.sh = v;
    s.par = 1'b0;
    return s;
  endfunction : fld

  function automatic bfs_m_s frame_start(input bfs_m_s s);
    s = fld(s, bfs_pkg::FLD_BC, 4'h0, {s.bc, 11'h000});
    s.cnt = 8'h00;
    s.nfr = 9'h000;
    s.frame = 1'b1;
    return s;
  endfunction : frame_start

  function automatic bfs_m_s finish(input bfs_m_s s, input bfs_pkg::bfs_res_e r);
    s.st = bfs_pkg::FLD_IDLE;
    s.frame = 1'b0;
    s.busy = 1'b0;
    s.done = 1'b1;
    s.res = r;
    return s;
  endfunction : finish

  // A refused byte stays pending, so a retry survives a frame split
  function automatic bfs_m_s ld_data(input bfs_m_s s, input logic [7:0] tx);
    s = fld(s, bfs_pkg::FLD_DATA, `BFS_BYTE_LAST, 12'hFFF);
    if (!s.rd && s.pend) begin
      s.sh = {s.tb, 4'h0}; // see R17
    end else if (!s.rd) begin
      s.sh = {tx, 4'h0}; // see R14
      s.tb = tx;
      s.pend = 1'b1;
      s.tx_take = 1'b1;
    end
    return s;
  endfunction : ld_data

  always_comb begin
    n = q;
    n.stb = 1'b0;
    n.tx_take = 1'b0;
    n.rx_vld = 1'b0;
    n.done = 1'b0;
    b = lnk.bus;
    bcm = (q.bc == `BFS_BC_FLAG); // see R22
    ack = (b == `BFS_ACK); // see R21
    acc = 1'b0;
    rm = q.rem;
    nf = q.nfr + 9'h001;
    maxb = mode ? 9'(MAX_M1) : 9'(MAX_M0); // see R24
    if (q.st == bfs_pkg::FLD_IDLE) begin
      if (start) begin
        n.bc = bcast;
        n.mad = own_adr;
        n.sad = dst_adr;
        n.ctl = ctl;
        n.rd = ~ctl[`BFS_DIR_BIT]; // see R11
        n.rem = bfs_pkg::bfs_len_bytes(len); // see R9
        n.pend = 1'b0;
        if (bcast == `BFS_BC_FLAG && !ctl[`BFS_DIR_BIT]) begin
          n.done = 1'b1;
          n.res = bfs_pkg::RES_BREAD; // see R15
        end else begin
          n = frame_start(n);
          n.busy = 1'b1;
        end
      end
    end else begin
      n.cnt = (q.cnt == LAST) ? 8'h00 : q.cnt + 8'h01;
      n.stb = q.frame && (q.cnt == PRE); // see R18
      if (q.cnt == LAST) begin
        if (q.ph == bfs_pkg::PH_BITS) begin
          n.sh = {q.sh[10:0], b};
          n.par = q.par ^ b;
          if (q.idx != 4'h0) n.idx = q.idx - 4'h1;
          else n.ph = bfs_pkg::PH_PAR;
        end else if (q.ph == bfs_pkg::PH_PAR) begin
          n.ok = (q.par == b); // see R20
          n.ph = bfs_pkg::PH_ACK;
        end
        case (q.st)
          bfs_pkg::FLD_BC: begin
            n = fld(n, bfs_pkg::FLD_MADR, `BFS_ADR_LAST, q.mad);
          end
          bfs_pkg::FLD_MADR: begin
            if (q.ph == bfs_pkg::PH_PAR) n = fld(n, bfs_pkg::FLD_SADR, `BFS_ADR_LAST, q.sad); // see R1
          end
          bfs_pkg::FLD_SADR: begin
            if (q.ph == bfs_pkg::PH_ACK) begin
              if (bcm || ack) n = fld(n, bfs_pkg::FLD_CTRL, `BFS_CTL_LAST, {q.ctl, 8'h00}); // see R2 R6
              else n = finish(n, bfs_pkg::RES_NADR); // see R3
            end
          end
          bfs_pkg::FLD_CTRL: begin
            if (q.ph == bfs_pkg::PH_ACK) begin
              if (bcm || ack) begin // see R8
                // On a read the line is released for the slave's length
                n = fld(n, bfs_pkg::FLD_LEN, `BFS_BYTE_LAST,
                        q.rd ? 12'hFFF : {bfs_pkg::bfs_len_code(q.rem), 4'h0}); // see R10
              end else begin
                n = finish(n, bfs_pkg::RES_NCTL);
              end
            end
          end
          bfs_pkg::FLD_LEN: begin
            if (q.ph == bfs_pkg::PH_ACK) begin
              if (q.rd ? q.ok : (bcm || ack)) begin // see R12 R13
                if (q.rd) n.rem = bfs_pkg::bfs_len_bytes(q.sh[7:0]);
                n = ld_data(n, tx_data);
              end else begin
                n = finish(n, bfs_pkg::RES_NLEN);
              end
            end
          end
          bfs_pkg::FLD_DATA: begin
            if (q.ph == bfs_pkg::PH_PAR) begin
              n.ok = (q.par == b) && !rx_full; // see R19
            end else if (q.ph == bfs_pkg::PH_ACK) begin
              acc = q.rd ? q.ok : (bcm || ack); // see R15 R17
              if (acc) begin
                rm = q.rem - 9'h001;
                n.pend = 1'b0;
                n.rx_vld = q.rd;
                n.rx_data = q.sh[7:0];
              end
              n.rem = rm;
              n.nfr = nf;
              if (rm == 9'h000) begin
                n = finish(n, bfs_pkg::RES_OK);
              end else if (nf == maxb) begin
                // One idle bit with the frame low, then a new frame
                n.st = bfs_pkg::FLD_REST; // see R10
                n.frame = 1'b0;
              end else begin
                n = ld_data(n, tx_data);
              end
            end
          end
          bfs_pkg::FLD_REST: begin
            n = frame_start(n);
          end
          default: begin
          end
        endcase
      end
    end
    // Drive for the position just reached; releasing leaves the line high
    mine = !(n.rd && (n.st == bfs_pkg::FLD_LEN || n.st == bfs_pkg::FLD_DATA));
    n.oe = 1'b0;
    n.o = 1'b1;
    if (n.st != bfs_pkg::FLD_IDLE && n.st != bfs_pkg::FLD_REST) begin
      if (n.ph == bfs_pkg::PH_BITS && mine) begin
        n.oe = 1'b1;
        n.o = n.sh[11];
      end else if (n.ph == bfs_pkg::PH_PAR && mine) begin
        n.oe = 1'b1;
        n.o = n.par; // see R20
      end else if (n.ph == bfs_pkg::PH_ACK && !mine && n.ok) begin
        n.oe = 1'b1;
        n.o = `BFS_ACK; // see R13 R23
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign tx_take   = q.tx_take;
  assign rx_data   = q.rx_data;
  assign rx_vld    = q.rx_vld;
  assign busy      = q.busy;
  assign done      = q.done;
  assign res       = q.res;
  assign lnk.frame = q.frame;
  assign lnk.stb   = q.stb;
  assign lnk.m_o   = q.o;
  assign lnk.m_oe  = q.oe;
endmodule : bfs_master

// *** tb/bfs_properties.sv ***
// Link-level assertions for the frame sequencer
module bfs_properties (
  input wire logic clock,  // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic frame,  // frame in progress
  input wire logic stb,    // bit sample strobe
  input wire logic m_o,    // master drive value
  input wire logic m_oe,   // master drive enable
  input wire logic s_o,    // slave drive value
  input wire logic s_oe,   // slave drive enable
  input wire logic bus     // resolved line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0]  nb_q;
  logic [11:0] sh_q;
  logic        bc_q;

  // Slot index and the last twelve line bits of the running frame
  always_ff @(posedge clock) begin
    if (!resetn || !frame) begin
      nb_q <= 10'h000;
      sh_q <= 12'h000;
      bc_q <= 1'b1;
    end else if (stb) begin
      nb_q <= nb_q + 10'h001;
      sh_q <= {sh_q[10:0], bus};
      if (nb_q == 10'h000) begin
        bc_q <= bus;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_stb_in_frame: assert property (stb |-> frame)
    else $error("strobe outside a frame");
  // Bench runs a four-cycle bit, so three quiet cycles follow each strobe
  a_stb_gap: assert property (stb |=> !stb [*3])
    else $error("strobes too close");
  a_stb_next: assert property (stb ##1 frame [*4] |-> stb)
    else $error("strobe missing in running frame");
  a_mst_hold: assert property (frame && $past(frame) && !$past(stb) |-> $stable(m_o) && $stable(m_oe))
    else $error("master drive changed mid bit");
  a_slv_hold: assert property (frame && $past(frame) && !$past(stb) |-> $stable(s_o) && $stable(s_oe))
    else $error("slave drive changed mid bit");
  a_idle_release: assert property (!frame && !$past(frame) && !$past(frame, 2) |-> !m_oe && !s_oe)
    else $error("line driven between frames");
  a_one_driver: assert property (!(m_oe && s_oe))
    else $error("both ends drive the line");
  a_addr_silent: assert property (frame && nb_q < 10'h01B |-> !s_oe)
    else $error("slave drove before address ack slot");
  a_ctl_silent: assert property (frame && nb_q inside {[10'h01C:10'h020]} |-> !s_oe)
    else $error("slave drove during control bits");
  a_bc_silent: assert property (frame && !bc_q && nb_q != 10'h000 |-> !s_oe)
    else $error("slave drove in broadcast");
  a_ack_release: assert property (frame && bc_q && nb_q == 10'h01B |-> !m_oe)
    else $error("master drove address ack slot");
  a_par_even: assert property (stb && (nb_q == 10'h00D || nb_q == 10'h01A) |-> bus == ^sh_q)
    else $error("address parity wrong");
endmodule : bfs_properties

// *** tb/bus_frame_field_sequencer_tb.sv ***
// Self-checking bench joining master and slave ends over one link
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module bus_frame_field_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] MA = 12'h5A3;
  localparam logic [11:0] SA = 12'h3C1;
  logic              clock, resetn, start, bcast, func_ok, rx_full, fr_q, mode;
  logic [11:0]       dst;
  logic [3:0]        ctl;
  logic [7:0]        len, m_tx, s_len, s_tx, m_rx, s_rx;
  logic [63:0]       cap;
  int                n_fail, checked, n_srx, n_drop;
  wire logic         m_take, m_vld, s_vld, done, busy, s_bc;
  wire logic [7:0]   m_rxd, s_rxd;
  wire logic [3:0]   s_ctl;
  wire logic [11:0]  s_mad;
  bfs_pkg::bfs_res_e res;

  bfs_if lnk ();
  // Short frames: two byte slots in mode 0 so a three-byte write must split, three in mode 1
  bfs_master #(.BIT_CYC(4), .MAX_M0(2), .MAX_M1(3)) u_bfs_master (.clock(clock), .resetn(resetn), .ce(1'b1),
    .mode(mode), .start(start), .bcast(bcast), .own_adr(MA), .dst_adr(dst), .ctl(ctl), .len(len), .tx_data(m_tx),
    .rx_full(1'b0), .tx_take(m_take), .rx_data(m_rxd), .rx_vld(m_vld), .busy(busy), .done(done), .res(res),
    .lnk(lnk.mst));
  bfs_slave #(.MAX_M0(2), .MAX_M1(3)) u_bfs_slave (.clock(clock), .resetn(resetn), .ce(1'b1), .mode(mode),
    .own_adr(SA), .func_ok(func_ok), .rx_full(rx_full), .tx_len(s_len), .tx_data(s_tx), .tx_take(), .rx_data(s_rxd),
    .rx_vld(s_vld), .sel(), .bc_rx(s_bc), .ctl_rx(s_ctl), .mad_rx(s_mad), .lnk(lnk.slv));
  bfs_properties u_bfs_properties (.clock(clock), .resetn(resetn), .frame(lnk.frame), .stb(lnk.stb), .m_o(lnk.m_o),
    .m_oe(lnk.m_oe), .s_o(lnk.s_o), .s_oe(lnk.s_oe), .bus(lnk.bus));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  always @(posedge clock) begin
    if (lnk.stb) cap <= {cap[62:0], lnk.bus};
    if (s_vld) begin
      s_rx  <= s_rxd;
      n_srx <= n_srx + 1;
    end
    if (m_vld) m_rx <= m_rxd;
    fr_q <= lnk.frame;
    if (fr_q && !lnk.frame) n_drop <= n_drop + 1;
  end
  always @(negedge clock) if (m_take) m_tx <= m_tx + 8'h01;

  task automatic xfer(input logic b, input logic [11:0] d, input logic [3:0] c, input logic [7:0] l,
                      input bfs_pkg::bfs_res_e r);
    int i;
    @(negedge clock);
    {bcast, dst, ctl, len, start} = {b, d, c, l, 1'b1};
    cap = '0;
    n_srx = 0;
    n_drop = 0;
    @(negedge clock);
    start = 1'b0;
    for (i = 0; i < 5000 && done !== 1'b1; i++) @(negedge clock);
    `CHK({done, busy}, 2'b10)
    `CHK(res, r)
    @(negedge clock);
    $display("Test ctl %0h dst %0h finished", c, d);
  endtask : xfer

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  initial begin
    {resetn, start, bcast, func_ok, rx_full, fr_q} = 6'h0C;
    {mode, dst, ctl, len, s_len, s_tx, m_tx, m_rx, s_rx, cap} = '0;
    s_len = 8'h01;
    s_tx = 8'hA5;
    repeat (20) @(posedge clock);
    @(negedge clock) resetn = 1'b1;
    m_tx = 8'h96;
    xfer(1'b1, SA, 4'hE, 8'h01, bfs_pkg::RES_OK);
    `CHK(cap[53:0], {1'b1, MA, ^MA, SA, ^SA, 1'b0, 4'hE, ^4'hE, 1'b0, 8'h01, ^8'h01, 1'b0, 8'h96, ^8'h96, 1'b0})
    `CHK(s_rx, 8'h96)
    `CHK({s_ctl, s_mad}, {4'hE, MA})
    xfer(1'b1, SA ^ 12'h001, 4'hE, 8'h01, bfs_pkg::RES_NADR);
    func_ok = 1'b0;
    xfer(1'b1, SA, 4'hE, 8'h01, bfs_pkg::RES_NCTL);
    func_ok = 1'b1;
    xfer(1'b1, SA, 4'h7, 8'h00, bfs_pkg::RES_OK);
    `CHK(m_rx, 8'hA5)
    for (int k = 0; k < 4; k++) begin
      m_tx = 8'h10 + 8'(k);
      rx_full = (k == 3);
      xfer(1'b0, k == 2 ? {~SA[11:8], 8'h77} : k == 1 ? {SA[11:8], 8'h77} : 12'hFFF, 4'hE, 8'h01,
           bfs_pkg::RES_OK);
      `CHK(n_srx, int'(k < 2))
      `CHK(s_bc, 1'b0)
    end
    rx_full = 1'b0;
    xfer(1'b0, 12'hFFF, 4'h7, 8'h01, bfs_pkg::RES_BREAD);
    m_tx = 8'h40;
    xfer(1'b1, SA, 4'hE, 8'h03, bfs_pkg::RES_OK);
    `CHK(n_srx, 3)
    `CHK(s_rx, 8'h42)
    `CHK(n_drop, 2)
    mode = 1'b1;
    m_tx = 8'h50;
    fork
      xfer(1'b1, SA, 4'hE, 8'h02, bfs_pkg::RES_OK);
      begin
        // Buffer busy over the first byte's parity slot only, so that byte is refused once
        rx_full = 1'b1;
        repeat (232) @(negedge clock);
        rx_full = 1'b0;
      end
    join
    `CHK(n_drop, 1)
    `CHK(n_srx, 2)
    `CHK(s_rx, 8'h51)
    end_sim;
  end

  // Each frame stays under 400 cycles, so a dozen of them fit with room to spare
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_sim;
  end
endmodule : bus_frame_field_sequencer_tb
